// *** hdl/uart_params.svh ***
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH
// register offsets on the host pins
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_ISR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SPR 3'h7
// field positions
`define FCR_EN 0
`define FCR_RXR 1
`define FCR_TXR 2
`define LCR_PEN 3
`define LCR_EVEN 4
`define LCR_FORCE 5
`define LCR_BRK 6
`define LCR_DLAB 7
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_OP1 2
`define MCR_OP2 3
`define MCR_LOOP 4
`define MCR_XANY 5
`define MCR_PRE 7
`define IER_RX 0
`define IER_TX 1
`define IER_LS 2
`define IER_MS 3
`define IER_XOFF 5
// reset values
`define SPR_RST 8'hff
`define DIV_RST 8'h00
// fifo geometry and trigger levels
`define FIFO_DEPTH 16
`define PTR_W 4
`define CNT_W 5
`define TRIG_1 5'h01
`define TRIG_4 5'h04
`define TRIG_8 5'h08
`define TRIG_14 5'h0e
// interrupt source codes
`define ISR_LSR 3'h3
`define ISR_TMO 3'h6
`define ISR_RXD 3'h2
`define ISR_TXR 3'h1
`define ISR_MDM 3'h0
// baud timing
`define PRE_MAX 2'h3
`define OVS_MAX 4'hf
`endif

// *** hdl/uart_pkg.sv ***
package uart_pkg;
`include "uart_params.svh"
  typedef enum logic [2:0] {PAR_NONE=3'h0, PAR_ODD=3'h1, PAR_EVEN=3'h2, PAR_MARK=3'h3, PAR_SPACE=3'h4} par_t;
  typedef enum logic [1:0] {STOP_1=2'h0, STOP_1H=2'h1, STOP_2=2'h2} stop_t;
  typedef struct packed {
    logic [1:0] wlen;
    stop_t stop;
    par_t par;
    logic brk;
  } fmt_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic xoff;
    logic xon;
    logic special;
  } rxchar_t;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] a;
    logic [7:0] d;
    logic alt;
    logic rxd;
  } pins_t;
  typedef struct packed {
    pins_t p1;
    pins_t p2;
    logic rd3;
    logic wr3;
    logic [7:0] line_control, modem_control, ier, spr, dll, divisor_high_byte;
    logic fifo_en;
    logic [1:0] rx_trig, tx_trig;
    logic [`FIFO_DEPTH-1:0][7:0] rx_mem, tx_mem;
    logic [`PTR_W-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
    logic [`CNT_W-1:0] rx_cnt, tx_cnt;
    logic txrdy, xoff_f, spec_f, cts_f;
    logic [7:0] dout;
    logic doe, txd, rxs, resume;
  } core_st_t;
  typedef struct packed {
    logic [1:0] pre;
    logic [15:0] div;
    logic [3:0] ovs;
    logic t16;
    logic bt;
  } baud_st_t;
endpackage : uart_pkg

// *** hdl/uart_baud_gen.sv ***
`timescale 1ns/1ns
`include "uart_params.svh"
module uart_baud_gen (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // rate selection
  input wire logic PRESCALE4,
  input wire logic [15:0] DIVISOR,
  // rate ticks
  output logic TICK16,
  output logic BIT_TICK
);
  import uart_pkg::*;
  baud_st_t q, n;
  logic pre_hit;

  assign pre_hit = !PRESCALE4 || q.pre == `PRE_MAX;

  always_comb begin
    n = q;
    n.t16 = 1'b0;
    n.bt = 1'b0;
    n.pre = PRESCALE4 ? q.pre + 2'h1 : 2'h0;
    if (pre_hit && DIVISOR != 16'h0000) begin
      if (q.div >= DIVISOR - 16'h0001) begin
        n.div = 16'h0000;
        n.t16 = 1'b1;
        n.ovs = q.ovs + 4'h1;
        n.bt = q.ovs == `OVS_MAX;
      end else begin
        n.div = q.div + 16'h0001;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign TICK16 = q.t16;
  assign BIT_TICK = q.bt;

  AST_BIT_IN_TICK: assert property (@(posedge REF_CLK) disable iff (RST) BIT_TICK |-> TICK16)
    else $error("bit tick without oversample tick");
endmodule : uart_baud_gen

// *** hdl/uart_regs_core.sv ***
`timescale 1ns/1ns
`include "uart_params.svh"
module uart_regs_core (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // host bus pins
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [2:0] A,
  input wire logic [7:0] D_I,
  output logic [7:0] D_O,
  output logic D_OE,
  input wire logic BUS_ALT,
  output logic IRQ_O,
  output logic IRQ_OE,
  // serial pins
  input wire logic RXD,
  output logic TXD,
  // enhanced feature control
  input wire logic EFR_EN,
  input wire logic SW_FLOW_ON,
  input wire logic CTS_RTS_OFF,
  // transmit engine side
  input wire logic TX_SER,
  input wire logic TX_IDLE,
  input wire logic TX_TAKE,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_RESUME,
  // receive engine side
  input wire uart_pkg::rxchar_t RX_IN,
  input wire logic LINE_ERR,
  input wire logic RX_TIMEOUT,
  input wire logic MODEM_INT,
  output logic RX_SER,
  // format and rate
  output uart_pkg::fmt_t FMT,
  output logic TICK16,
  output logic BIT_TICK
);
  import uart_pkg::*;

  // ==========================================================
  // bus decode
  core_st_t q, n;
  logic [2:0] adr;
  logic [7:0] wd;
  logic dlab, wr_ev, rd_ev;
  logic thr_wr, rhr_rd, isr_rd, fcr_wr;
  logic rx_clr, tx_clr;

  assign adr = q.p2.a;
  assign wd = q.p2.d;
  assign dlab = q.line_control[`LCR_DLAB];
  assign wr_ev = !q.p2.wr_n && q.wr3 && !q.p2.cs_n;
  assign rd_ev = !q.p2.rd_n && q.rd3 && !q.p2.cs_n;
  assign thr_wr = wr_ev && adr == `OFS_DATA && !dlab;
  assign rhr_rd = rd_ev && adr == `OFS_DATA && !dlab;
  assign isr_rd = rd_ev && adr == `OFS_ISR;
  assign fcr_wr = wr_ev && adr == `OFS_ISR;
  assign rx_clr = fcr_wr && wd[`FCR_EN] && wd[`FCR_RXR];
  assign tx_clr = fcr_wr && wd[`FCR_EN] && wd[`FCR_TXR];

  // ==========================================================
  // fifo levels
  logic [`CNT_W-1:0] depth, rx_lvl, tx_lvl, rx_cnt_nx, tx_cnt_nx;
  logic rx_keep, rx_push, rx_pop, tx_push, tx_pop, rx_hit;

  function automatic logic [`CNT_W-1:0] trig_lvl(input logic [1:0] sel);
    case (sel)
      2'h0: trig_lvl = `TRIG_1;
      2'h1: trig_lvl = `TRIG_4;
      2'h2: trig_lvl = `TRIG_8;
      default: trig_lvl = `TRIG_14;
    endcase
  endfunction : trig_lvl

  assign depth = q.fifo_en ? `CNT_W'(`FIFO_DEPTH) : `TRIG_1;
  assign rx_lvl = q.fifo_en ? trig_lvl(q.rx_trig) : `TRIG_1;
  assign tx_lvl = q.fifo_en ? trig_lvl(q.tx_trig) : `TRIG_1;
  assign rx_keep = RX_IN.valid && !(SW_FLOW_ON && (RX_IN.xon || RX_IN.xoff));
  assign rx_push = rx_keep && q.rx_cnt < depth;
  assign rx_pop = rhr_rd && q.rx_cnt != '0;
  assign tx_push = thr_wr && q.tx_cnt < depth;
  assign tx_pop = TX_TAKE && q.tx_cnt != '0;
  assign rx_cnt_nx = rx_clr ? '0 : q.rx_cnt + `CNT_W'(rx_push) - `CNT_W'(rx_pop);
  assign tx_cnt_nx = tx_clr ? '0 : q.tx_cnt + `CNT_W'(tx_push) - `CNT_W'(tx_pop);
  assign rx_hit = q.rx_cnt >= rx_lvl && q.rx_cnt != '0;

  // ==========================================================
  // interrupt status
  logic [2:0] code;
  logic any;
  logic [7:0] isr_val, lsr_val, msr_val;
  logic xoff_set, tx_fall;

  always_comb begin
    any = 1'b1;
    code = `ISR_MDM;
    if (LINE_ERR && q.ier[`IER_LS]) begin
      code = `ISR_LSR;
    end else if (RX_TIMEOUT && q.ier[`IER_RX]) begin
      code = `ISR_TMO;
    end else if (rx_hit && q.ier[`IER_RX]) begin
      code = `ISR_RXD;
    end else if (q.txrdy && q.ier[`IER_TX]) begin
      code = `ISR_TXR;
    end else if (MODEM_INT && q.ier[`IER_MS]) begin
      code = `ISR_MDM;
    end else if (EFR_EN && q.ier[`IER_XOFF] && (q.xoff_f || q.cts_f)) begin
      code = `ISR_MDM;
    end else begin
      any = 1'b0;
    end
  end

  assign isr_val = {{2{q.fifo_en}}, q.cts_f && EFR_EN, q.xoff_f && EFR_EN, code, !any};
  assign lsr_val = {1'b0, q.tx_cnt == '0 && TX_IDLE, q.tx_cnt == '0, 4'h0, q.rx_cnt != '0};
  assign xoff_set = EFR_EN && RX_IN.valid && (RX_IN.xoff || RX_IN.special);
  assign tx_fall = (tx_cnt_nx < tx_lvl && q.tx_cnt >= tx_lvl) || (tx_cnt_nx == '0 && q.tx_cnt != '0);

  // ==========================================================
  // modem loopback
  logic loop_dtr_n, loop_rts_n, loopback_ring_out, loopback_carrier_out, lb, tx_line;

  assign lb = q.modem_control[`MCR_LOOP];
  assign loop_dtr_n = !q.modem_control[`MCR_DTR];
  assign loop_rts_n = !q.modem_control[`MCR_RTS];
  assign loopback_ring_out = !q.modem_control[`MCR_OP1];
  assign loopback_carrier_out = !q.modem_control[`MCR_OP2];
  assign msr_val = lb ? {!loopback_carrier_out, !loopback_ring_out, !loop_dtr_n, !loop_rts_n, 4'h0} : 8'h00;
  assign tx_line = q.line_control[`LCR_BRK] ? 1'b0 : TX_SER;

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    n.p1 = '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, a: A, d: D_I, alt: BUS_ALT, rxd: RXD};
    n.p2 = q.p1;
    n.rd3 = q.p2.rd_n;
    n.wr3 = q.p2.wr_n;
    n.doe = !q.p2.cs_n && !q.p2.rd_n;
    n.txd = lb ? 1'b1 : tx_line;
    n.rxs = lb ? tx_line : q.p2.rxd;
    n.resume = q.modem_control[`MCR_XANY] && RX_IN.valid;
    if (rx_push) begin
      n.rx_mem[q.rx_wp] = RX_IN.data;
      n.rx_wp = q.rx_wp + `PTR_W'(1);
    end
    if (rx_pop) begin
      n.rx_rp = q.rx_rp + `PTR_W'(1);
    end
    if (tx_push) begin
      n.tx_mem[q.tx_wp] = wd;
      n.tx_wp = q.tx_wp + `PTR_W'(1);
    end
    if (tx_pop) begin
      n.tx_rp = q.tx_rp + `PTR_W'(1);
    end
    n.rx_cnt = rx_cnt_nx;
    n.tx_cnt = tx_cnt_nx;
    if (rx_clr) begin
      n.rx_wp = '0;
      n.rx_rp = '0;
    end
    if (tx_clr) begin
      n.tx_wp = '0;
      n.tx_rp = '0;
    end
    // interrupt flags, set wins over clear
    if (tx_fall) begin
      n.txrdy = 1'b1;
    end else if (isr_rd || thr_wr) begin
      n.txrdy = 1'b0;
    end
    if (xoff_set) begin
      n.xoff_f = 1'b1;
      n.spec_f = RX_IN.special;
    end else if (isr_rd || (RX_IN.valid && (q.spec_f || RX_IN.xon))) begin
      n.xoff_f = 1'b0;
      n.spec_f = 1'b0;
    end
    if (EFR_EN && CTS_RTS_OFF) begin
      n.cts_f = 1'b1;
    end else if (isr_rd) begin
      n.cts_f = 1'b0;
    end
    // register writes
    if (wr_ev) begin
      case (adr)
        `OFS_DATA: begin
          if (dlab) begin
            n.dll = wd;
          end
        end
        `OFS_IER: begin
          if (dlab) begin
            n.divisor_high_byte = wd;
          end else begin
            n.ier = wd;
          end
        end
        `OFS_ISR: begin
          n.fifo_en = wd[`FCR_EN];
          if (wd[`FCR_EN]) begin
            n.rx_trig = wd[7:6];
            if (EFR_EN) begin
              n.tx_trig = wd[5:4];
            end
          end
        end
        `OFS_LCR: n.line_control = wd;
        `OFS_MCR: n.modem_control = wd;
        `OFS_SPR: n.spr = wd;
        default: n.spr = q.spr;
      endcase
    end
    // register reads
    if (rd_ev) begin
      case (adr)
        `OFS_DATA: n.dout = dlab ? q.dll : q.rx_mem[q.rx_rp];
        `OFS_IER: n.dout = dlab ? q.divisor_high_byte : q.ier;
        `OFS_ISR: n.dout = isr_val;
        `OFS_LCR: n.dout = q.line_control;
        `OFS_MCR: n.dout = q.modem_control;
        `OFS_LSR: n.dout = lsr_val;
        `OFS_MSR: n.dout = msr_val;
        default: n.dout = q.spr;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.p1.cs_n <= 1'b1;
      q.p1.rd_n <= 1'b1;
      q.p1.wr_n <= 1'b1;
      q.p1.rxd <= 1'b1;
      q.p2.cs_n <= 1'b1;
      q.p2.rd_n <= 1'b1;
      q.p2.wr_n <= 1'b1;
      q.p2.rxd <= 1'b1;
      q.rd3 <= 1'b1;
      q.wr3 <= 1'b1;
      q.spr <= `SPR_RST;
      q.dll <= `DIV_RST;
      q.divisor_high_byte <= `DIV_RST;
      q.txd <= 1'b1;
      q.rxs <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    FMT.wlen = q.line_control[1:0];
    FMT.brk = q.line_control[`LCR_BRK];
    FMT.stop = STOP_1;
    if (q.line_control[2]) begin
      FMT.stop = q.line_control[1:0] == 2'h0 ? STOP_1H : STOP_2;
    end
    FMT.par = PAR_NONE;
    if (q.line_control[`LCR_PEN] && q.line_control[`LCR_FORCE]) begin
      FMT.par = q.line_control[`LCR_EVEN] ? PAR_SPACE : PAR_MARK;
    end else if (q.line_control[`LCR_PEN]) begin
      FMT.par = q.line_control[`LCR_EVEN] ? PAR_EVEN : PAR_ODD;
    end
  end

  assign D_O = q.dout;
  assign D_OE = q.doe;
  assign IRQ_OE = q.p2.alt || q.modem_control[`MCR_OP2];
  assign IRQ_O = q.p2.alt ? !any : any;
  assign TXD = q.txd;
  assign RX_SER = q.rxs;
  assign TX_VALID = q.tx_cnt != '0;
  assign TX_DATA = q.tx_mem[q.tx_rp];
  assign TX_RESUME = q.resume;

  uart_baud_gen u_baud (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .PRESCALE4(q.modem_control[`MCR_PRE]),
    .DIVISOR({q.divisor_high_byte, q.dll}),
    .TICK16(TICK16),
    .BIT_TICK(BIT_TICK)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_fcr_on;
    fcr_wr && wd[`FCR_EN];
  endsequence
  sequence s_rx_char;
    RX_IN.valid && q.modem_control[`MCR_XANY];
  endsequence

  AST_FIFO_STATUS: assert property (s_fcr_on |=> isr_val[7:6] == 2'b11)
    else $error("fifo enable not shown in isr");
  AST_FCR_IGNORE: assert property (fcr_wr && !wd[`FCR_EN] |=> $stable(q.rx_trig) && !q.fifo_en)
    else $error("fcr bits taken without enable");
  AST_RX_CLEAR: assert property (s_fcr_on ##0 wd[`FCR_RXR] |=> q.rx_cnt == '0 && q.rx_wp == q.rx_rp)
    else $error("rx fifo not cleared");
  AST_TX_CLEAR: assert property (s_fcr_on ##0 wd[`FCR_TXR] |=> q.tx_cnt == '0 && !TX_VALID)
    else $error("tx fifo not cleared");
  AST_TXTRIG_LOCK: assert property (fcr_wr && !EFR_EN |=> $stable(q.tx_trig))
    else $error("tx trigger written without enhanced mode");
  AST_TX_EMPTY_IRQ: assert property (q.tx_cnt != '0 && tx_cnt_nx == '0 |=> q.txrdy)
    else $error("tx interrupt missing on empty");
  AST_BREAK: assert property (q.line_control[`LCR_BRK] && !lb |=> !TXD)
    else $error("break not driven low");
  AST_LSR0: assert property (rd_ev && adr == `OFS_LSR |=> q.dout[0] == ($past(q.rx_cnt) != '0))
    else $error("data ready bit wrong");
  AST_LOOP_MSR: assert property (rd_ev && adr == `OFS_MSR && lb |=> q.dout[6] == $past(q.modem_control[2]) && q.dout[4] == $past(q.modem_control[1]))
    else $error("loopback modem status wrong");
  AST_IRQ_TRI: assert property (!q.p2.alt && !q.modem_control[`MCR_OP2] |-> !IRQ_OE)
    else $error("irq pin driven while disabled");
  AST_XON_ANY: assert property (s_rx_char |=> TX_RESUME ##1 !TX_RESUME || $past(RX_IN.valid))
    else $error("xon-any resume missing");
  AST_XOFF_FLAG: assert property (xoff_set |=> q.xoff_f)
    else $error("xoff match not flagged");
  AST_CTS_FLAG: assert property (EFR_EN && CTS_RTS_OFF |=> q.cts_f)
    else $error("handshake deassert not flagged");
endmodule : uart_regs_core

// *** sim/uart_host_model.sv ***
`timescale 1ns/1ns
`include "uart_params.svh"
module uart_host_model (
  // clock and strap
  input wire logic REF_CLK,
  input wire logic ALT,
  // bus pins toward the device
  output logic CS_N,
  output logic RD_N,
  output logic WR_N,
  output logic [2:0] A,
  output logic [7:0] D_I,
  // read answer
  input wire logic [7:0] D_O,
  input wire logic D_OE
);
  initial begin
    CS_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    A = 3'h0;
    D_I = 8'h00;
  end

  // ==========================================================
  // one bus cycle: address and data settle before the strobe
  task automatic xfer(input logic rd, input logic [2:0] adr, input logic [7:0] wd, output logic [7:0] rdat);
    @(posedge REF_CLK);
    CS_N <= 1'b0;
    A <= adr;
    D_I <= wd;
    @(posedge REF_CLK);
    if (rd) begin
      RD_N <= 1'b0;
    end else begin
      WR_N <= 1'b0;
    end
    repeat (4) @(posedge REF_CLK);
    rdat = D_OE ? D_O : 8'hxx;
    CS_N <= 1'b1;
    RD_N <= 1'b1;
    WR_N <= 1'b1;
    // released data no longer shows the written value
    D_I <= ~wd;
    repeat (3) @(posedge REF_CLK);
  endtask : xfer

  task automatic fcr_wr(input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b0, `OFS_ISR, v | 8'h01, r);
  endtask : fcr_wr

  task automatic mcr_wr(input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b0, `OFS_MCR, ALT ? (v & 8'hf7) : v, r);
  endtask : mcr_wr
endmodule : uart_host_model

// *** sim/test_uart_regs_core.sv ***
`timescale 1ns/1ns
`include "uart_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module test_uart_regs_core;
  import uart_pkg::*;
  logic ref_clk, rst, cs_n, rd_n, wr_n, d_oe, irq_o, irq_oe, rxd, txd;
  logic efr_en, sw_flow_on, cts_rts_off, tx_ser, tx_take, tx_valid, tx_resume;
  logic line_err, rx_ser, tick16, bit_tick;
  logic bus_alt, tx_idle, rx_timeout, modem_int;
  logic [2:0] a;
  logic [7:0] d_i, d_o, tx_data, r;
  rxchar_t rx_in;
  fmt_t fmt;
  int mismatches = 0;
  int checks_done = 0;
  int n;

  uart_host_model host (.REF_CLK(ref_clk), .ALT(bus_alt), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .A(a),
    .D_I(d_i), .D_O(d_o), .D_OE(d_oe));
  uart_regs_core uut (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .A(a),
    .D_I(d_i), .D_O(d_o), .D_OE(d_oe), .BUS_ALT(bus_alt), .IRQ_O(irq_o), .IRQ_OE(irq_oe), .RXD(rxd),
    .TXD(txd), .EFR_EN(efr_en), .SW_FLOW_ON(sw_flow_on), .CTS_RTS_OFF(cts_rts_off), .TX_SER(tx_ser),
    .TX_IDLE(tx_idle), .TX_TAKE(tx_take), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_RESUME(tx_resume),
    .RX_IN(rx_in), .LINE_ERR(line_err), .RX_TIMEOUT(rx_timeout), .MODEM_INT(modem_int), .RX_SER(rx_ser),
    .FMT(fmt), .TICK16(tick16), .BIT_TICK(bit_tick));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // bench tasks
  task automatic wr(input logic [2:0] ad, input logic [7:0] dv);
    logic [7:0] x;
    host.xfer(1'b0, ad, dv, x);
  endtask : wr

  task automatic rd(input logic [2:0] ad, input logic [7:0] ev);
    logic [7:0] x;
    host.xfer(1'b1, ad, 8'h00, x);
    `CHK(x, ev)
  endtask : rd

  task automatic push(input logic [7:0] dv, input logic xf, input logic xn, input logic sp, input logic er);
    logic res;
    @(posedge ref_clk);
    rx_in <= '{1'b1, dv, xf, xn, sp};
    @(posedge ref_clk);
    rx_in.valid <= 1'b0;
    res = 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      if (tx_resume === 1'b1) res = 1'b1;
    end
    `CHK(res, er)
  endtask : push

  task automatic pop();
    @(posedge ref_clk);
    tx_take <= 1'b1;
    @(posedge ref_clk);
    tx_take <= 1'b0;
    @(posedge ref_clk);
  endtask : pop

  task automatic period(input logic bt, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while ((bt ? bit_tick : tick16) !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    do begin
      @(posedge ref_clk);
      cnt++;
    end while ((bt ? bit_tick : tick16) !== 1'b1 && cnt < 400);
  endtask : period

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    #(20000 * 50);
    mismatches++;
    $display("Error at %0t ns: watchdog expired", $time);
    summarize();
  end

  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    rx_in = '0;
    rxd = 1'b1;
    efr_en = 1'b0;
    sw_flow_on = 1'b0;
    cts_rts_off = 1'b0;
    tx_ser = 1'b1;
    tx_take = 1'b0;
    line_err = 1'b0;
    bus_alt = 1'b0;
    tx_idle = 1'b1;
    rx_timeout = 1'b0;
    modem_int = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`OFS_LCR, 8'h00);
    rd(`OFS_MCR, 8'h00);
    rd(`OFS_ISR, 8'h01);
    rd(`OFS_LSR, 8'h60);
    // shifter busy clears the all-empty bit only
    @(posedge ref_clk) tx_idle <= 1'b0;
    rd(`OFS_LSR, 8'h20);
    @(posedge ref_clk) tx_idle <= 1'b1;
    rd(`OFS_SPR, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      wr(`OFS_LCR, 8'(i));
      rd(`OFS_LCR, 8'(i));
      `CHK(fmt.wlen, i[1:0])
      `CHK(fmt.stop, !i[2] ? STOP_1 : (i[1:0] == 2'h0 ? STOP_1H : STOP_2))
      `CHK(fmt.par, !i[3] ? PAR_NONE : i[5] ? (i[4] ? PAR_SPACE : PAR_MARK) : (i[4] ? PAR_EVEN : PAR_ODD))
    end
    wr(`OFS_LCR, 8'h40);
    `CHK(txd, 1'b0)
    `CHK(fmt.brk, 1'b1)
    wr(`OFS_LCR, 8'h00);
    `CHK(txd, 1'b1)
    $display("test format done");
    wr(`OFS_LCR, 8'h80);
    wr(`OFS_DATA, 8'h02);
    wr(`OFS_IER, 8'h00);
    rd(`OFS_DATA, 8'h02);
    wr(`OFS_LCR, 8'h03);
    rd(`OFS_LSR, 8'h60);
    period(1'b0, n);
    `CHK(n, 2)
    host.mcr_wr(8'h80);
    period(1'b0, n);
    `CHK(n, 8)
    period(1'b1, n);
    `CHK(n, 128)
    host.mcr_wr(8'h00);
    $display("test baud done");
    host.fcr_wr(8'h43);
    wr(`OFS_IER, 8'h05);
    for (int i = 0; i < 3; i++) begin
      push(8'ha0 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0);
      rd(`OFS_ISR, 8'hc1);
    end
    push(8'ha3, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(`OFS_ISR, 8'hc4);
    host.mcr_wr(8'h08);
    `CHK(irq_oe, 1'b1)
    `CHK(irq_o, 1'b1)
    @(posedge ref_clk) line_err <= 1'b1;
    rd(`OFS_ISR, 8'hc6);
    @(posedge ref_clk) line_err <= 1'b0;
    rx_timeout <= 1'b1;
    rd(`OFS_ISR, 8'hcc);
    @(posedge ref_clk) rx_timeout <= 1'b0;
    rd(`OFS_LSR, 8'h61);
    for (int i = 0; i < 4; i++) rd(`OFS_DATA, 8'ha0 + 8'(i));
    rd(`OFS_LSR, 8'h60);
    host.mcr_wr(8'h00);
    `CHK(irq_oe, 1'b0)
    push(8'hb0, 1'b0, 1'b0, 1'b0, 1'b0);
    push(8'hb1, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`OFS_ISR, 8'h02);
    rd(`OFS_ISR, 8'h04);
    rd(`OFS_LSR, 8'h61);
    host.fcr_wr(8'h03);
    rd(`OFS_LSR, 8'h60);
    rd(`OFS_ISR, 8'hc1);
    $display("test rx fifo done");
    wr(`OFS_IER, 8'h02);
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk) efr_en <= (p == 0);
      host.fcr_wr(p == 0 ? 8'h17 : 8'h37);
      for (int j = 0; j < 5; j++) wr(`OFS_DATA, 8'h10 + 8'(j));
      `CHK(tx_data, 8'h10)
      host.xfer(1'b1, `OFS_ISR, 8'h00, r);
      pop();
      rd(`OFS_ISR, 8'hc1);
      `CHK(tx_data, 8'h11)
      pop();
      rd(`OFS_ISR, 8'hc2);
      host.fcr_wr(p == 0 ? 8'h17 : 8'h37);
      `CHK(tx_valid, 1'b0)
      rd(`OFS_LSR, 8'h60);
    end
    $display("test tx fifo done");
    @(posedge ref_clk) efr_en <= 1'b1;
    wr(`OFS_IER, 8'h20);
    push(8'h13, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(`OFS_ISR, 8'hd0);
    rd(`OFS_ISR, 8'hc1);
    @(posedge ref_clk) cts_rts_off <= 1'b1;
    @(posedge ref_clk) cts_rts_off <= 1'b0;
    rd(`OFS_ISR, 8'he0);
    rd(`OFS_ISR, 8'hc1);
    push(8'h41, 1'b0, 1'b0, 1'b1, 1'b0);
    `CHK(irq_o, 1'b1)
    push(8'h42, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(irq_o, 1'b0)
    host.mcr_wr(8'h20);
    @(posedge ref_clk) sw_flow_on <= 1'b1;
    host.fcr_wr(8'h03);
    push(8'h11, 1'b0, 1'b1, 1'b0, 1'b1);
    rd(`OFS_LSR, 8'h60);
    push(8'h55, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(`OFS_LSR, 8'h61);
    $display("test flags done");
    host.mcr_wr(8'h15);
    rd(`OFS_MSR, 8'h60);
    host.mcr_wr(8'h1a);
    rd(`OFS_MSR, 8'h90);
    @(posedge ref_clk) tx_ser <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(rx_ser, 1'b0)
    `CHK(txd, 1'b1)
    @(posedge ref_clk) tx_ser <= 1'b1;
    host.mcr_wr(8'h00);
    @(posedge ref_clk) rxd <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK(rx_ser, 1'b0)
    @(posedge ref_clk) rxd <= 1'b1;
    $display("test loopback done");
    // alternate bus mode: irq always driven, active low
    wr(`OFS_IER, 8'h08);
    @(posedge ref_clk) bus_alt <= 1'b1;
    @(posedge ref_clk) modem_int <= 1'b1;
    host.mcr_wr(8'h08);
    rd(`OFS_MCR, 8'h00);
    `CHK(irq_oe, 1'b1)
    `CHK(irq_o, 1'b0)
    rd(`OFS_ISR, 8'hc0);
    @(posedge ref_clk) modem_int <= 1'b0;
    rd(`OFS_ISR, 8'hc1);
    `CHK(irq_o, 1'b1)
    @(posedge ref_clk) bus_alt <= 1'b0;
    $display("test alt mode done");
    summarize();
  end
endmodule : test_uart_regs_core
